// ==== pkg/orm_pkg.sv ====
/*
  package for the output routing matrix: crosspoint states, sizes,
  reset values and the output-state carrier.
  assumes single-clock use by rtl/orm_top.sv and rtl/orm_cell.sv.
*/
package orm_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int ORM_NUM_TRIP   = 7;
  localparam int ORM_NUM_OUT    = ORM_NUM_TRIP + 2;
  localparam int ORM_NUM_IN     = 16;
  localparam int ORM_NUM_LOGIC  = 8;
  localparam int ORM_IDX_ALARM  = 7;
  localparam int ORM_IDX_SERV   = 8;

  // ----------------------------------------
  // crosspoint states, advanced cyclically
  // ----------------------------------------
  typedef enum logic [1:0] {
    ORM_XP_NONE,
    ORM_XP_CONN,
    ORM_XP_LATCH
  } orm_xp_t;

  localparam orm_xp_t ORM_XP_RESET    = ORM_XP_NONE;
  localparam logic    ORM_FORCE_RESET = 1'b0;
  localparam logic    ORM_OUT_RESET   = 1'b0;

  // ----------------------------------------
  // output carrier
  // ----------------------------------------
  typedef struct packed {
    logic [ORM_NUM_TRIP-1:0] trip;
    logic                    alarm;
    logic                    service;
  } orm_outs_t;

endpackage : orm_pkg

// ==== rtl/orm_cell.sv ====
/*
  one crosspoint: three-state selector and the held value of a latched link.
  assumes select, release and source are synchronous to sys_clk_i.
*/
`timescale 1ns/100ps
module orm_cell (
  input  wire logic             sys_clk_i,
  input  wire logic             reset_i,
  input  wire logic             select_i,
  input  wire logic             release_i,
  input  wire logic             src_i,
  output orm_pkg::orm_xp_t      state_o,
  output logic                  contrib_o
);
  import orm_pkg::*;

  typedef struct packed {
    orm_xp_t xp;
    logic    held;
  } orm_cell_st_t;

  orm_cell_st_t st;
  orm_cell_st_t next_st;

  always_comb begin
    next_st = st;
    if (select_i) begin
      case (st.xp)
        ORM_XP_NONE:  next_st.xp = ORM_XP_CONN;
        ORM_XP_CONN:  next_st.xp = ORM_XP_LATCH;
        ORM_XP_LATCH: next_st.xp = ORM_XP_NONE;
        default:      next_st.xp = ORM_XP_NONE;
      endcase
    end
    // source set wins over a simultaneous release
    if (st.xp == ORM_XP_LATCH && src_i) begin
      next_st.held = 1'b1;
    end else if (release_i || st.xp != ORM_XP_LATCH) begin
      next_st.held = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st <= '{xp: ORM_XP_RESET, held: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign state_o = st.xp;
  // latched links give the held value or-ed with the live one
  assign contrib_o = (st.xp == ORM_XP_CONN) ? src_i :
                     (st.xp == ORM_XP_LATCH) ? (src_i | st.held) : 1'b0;

endmodule : orm_cell

// ==== rtl/orm_top.sv ====
/*
  output routing matrix: sources (rows) to trip, alarm and service outputs
  (columns) with per-output latching and test forcing.
  assumes synchronous inputs on sys_clk_i; select strobes are one-cycle pulses.
*/
`timescale 1ns/100ps
module orm_top #(
  parameter int N_IN    = orm_pkg::ORM_NUM_IN,
  parameter int N_LOGIC = orm_pkg::ORM_NUM_LOGIC
) (
  input  wire logic                          sys_clk_i,
  input  wire logic                          reset_i,
  input  wire logic [N_IN-1:0]               signals_i,
  input  wire logic [N_LOGIC-1:0]            logic_outs_i,
  input  wire logic                          xp_select_i,
  input  wire logic [7:0]                    xp_row_i,
  input  wire logic [3:0]                    xp_col_i,
  input  wire logic [orm_pkg::ORM_NUM_OUT-1:0] out_latching_i,
  input  wire logic                          enter_key_i,
  input  wire logic                          tool_release_i,
  input  wire logic                          force_set_i,
  input  wire logic                          force_clear_i,
  input  wire logic                          force_write_i,
  input  wire orm_pkg::orm_outs_t            force_value_i,
  output orm_pkg::orm_outs_t                 outputs_o,
  output orm_pkg::orm_outs_t                 matrix_status_o,
  output logic                               force_en_o
);
  import orm_pkg::*;

  localparam int N_ROW = N_IN + N_LOGIC;

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  // a matrix with no stage rows or no logic rows would leave empty
  if (N_IN < 1) begin : g_chk_in
    $error("orm_top: N_IN must be at least 1");
  end

  if (N_LOGIC < 1) begin : g_chk_logic
    $error("orm_top: N_LOGIC must be at least 1");
  end

  // the row index port is 8 bits wide, so more rows cannot be addressed
  if (N_ROW > 256) begin : g_chk_rows
    $error("orm_top: row count must be 1..256");
  end

  // the column index port is 4 bits wide
  if (ORM_NUM_OUT > 16) begin : g_chk_cols
    $error("orm_top: column count must be 1..16");
  end

  // column order is trips first, then alarm, then service
  if (ORM_IDX_ALARM != ORM_NUM_TRIP || ORM_IDX_SERV != ORM_NUM_OUT - 1) begin : g_chk_map
    $error("orm_top: alarm and service columns must follow the trips");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic      force_en;
    orm_outs_t forced;
    orm_outs_t out;
    orm_outs_t mstat;
  } orm_st_t;

  orm_st_t st;
  orm_st_t next_st;

  // logic outputs append to the row list with no extra setup
  logic [N_ROW-1:0]         rows;
  assign rows = {logic_outs_i, signals_i};

  logic                     release_cmd;
  assign release_cmd = enter_key_i | tool_release_i;

  logic [ORM_NUM_OUT-1:0]   col_or;
  logic [ORM_NUM_OUT-1:0]   col_hold;
  logic [ORM_NUM_OUT-1:0]   col_raw;
  orm_outs_t                col_outs;

  // ----------------------------------------
  // index decode
  // ----------------------------------------
  // one compare per row and per column instead of one per crosspoint
  logic [N_ROW-1:0]         row_hit;
  logic [ORM_NUM_OUT-1:0]   col_hit;

  for (genvar r = 0; r < N_ROW; r++) begin : g_row_dec
    assign row_hit[r] = (xp_row_i == 8'(r));
  end

  // out-of-range indices hit nothing and are ignored
  for (genvar c = 0; c < ORM_NUM_OUT; c++) begin : g_col_dec
    assign col_hit[c] = (xp_col_i == 4'(c));
  end

  // ----------------------------------------
  // crosspoint grid
  // ----------------------------------------
  for (genvar c = 0; c < ORM_NUM_OUT; c++) begin : g_col
    logic [N_ROW-1:0] contrib;
    for (genvar r = 0; r < N_ROW; r++) begin : g_row
      logic sel;
      assign sel = xp_select_i && row_hit[r] && col_hit[c];
      orm_cell u_cell (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .select_i  (sel),
        .release_i (release_cmd),
        .src_i     (rows[r]),
        .state_o   (),
        .contrib_o (contrib[r])
      );
    end
    assign col_or[c] = |contrib;
    // a latching output holds its column result until release
    assign col_raw[c] = col_or[c] | (out_latching_i[c] & col_hold[c]);
  end

  // hold register of latching outputs; release clears it outright because
  // col_or still carries crosspoint-held values in the release cycle. a live
  // source keeps the output up through col_or and re-arms the hold next cycle
  logic [ORM_NUM_OUT-1:0] hold_q;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      hold_q <= '0;
    end else begin
      hold_q <= out_latching_i & ~{ORM_NUM_OUT{release_cmd}} & (col_or | hold_q);
    end
  end
  assign col_hold = hold_q;

  // ----------------------------------------
  // column to output mapping
  // ----------------------------------------
  // columns 0..6 are trips, 7 alarm, 8 service; the struct holds service
  // in bit 0, so a plain cast of the column vector would reverse them
  always_comb begin
    col_outs         = '0;
    col_outs.trip    = col_raw[ORM_NUM_TRIP-1:0];
    col_outs.alarm   = col_raw[ORM_IDX_ALARM];
    col_outs.service = col_raw[ORM_IDX_SERV];
  end

  // ----------------------------------------
  // force control and output selection
  // ----------------------------------------
  always_comb begin
    next_st = st;
    if (force_set_i) begin
      next_st.force_en = 1'b1;
    end else if (force_clear_i) begin
      next_st.force_en = 1'b0;
    end
    if (st.force_en && force_write_i) begin
      next_st.forced = force_value_i;
    end
    next_st.mstat = col_outs;
    if (next_st.force_en) begin
      next_st.out = next_st.forced;
    end else begin
      next_st.out = col_outs;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st.force_en <= ORM_FORCE_RESET;
      st.forced   <= '0;
      st.out      <= '0;
      st.mstat    <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign outputs_o       = st.out;
  assign matrix_status_o = st.mstat;
  assign force_en_o      = st.force_en;

endmodule : orm_top

// ==== dv/orm_top_monitor.sv ====
/* checker on orm_top ports; bound below. needs orm_pkg. */
`timescale 1ns/100ps
module orm_top_monitor #(
  parameter int N_IN    = 16,
  parameter int N_LOGIC = 8
) (
  input wire logic               sys_clk_i,
  input wire logic               reset_i,
  input wire logic [N_IN-1:0]    signals_i,
  input wire logic [N_LOGIC-1:0] logic_outs_i,
  input wire logic               enter_key_i,
  input wire logic               tool_release_i,
  input wire logic               force_set_i,
  input wire logic               force_clear_i,
  input wire logic               force_write_i,
  input wire orm_pkg::orm_outs_t force_value_i,
  input wire orm_pkg::orm_outs_t outputs_o,
  input wire orm_pkg::orm_outs_t matrix_status_o,
  input wire logic               force_en_o
);
  import orm_pkg::*;
  wire quiet = !(|signals_i) && !(|logic_outs_i);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // release seen with no source high across the two-stage clear
  sequence rel_s;
    (enter_key_i || tool_release_i) && quiet ##1 quiet;
  endsequence
  AST_RESET: assert property ($fell(reset_i) |-> outputs_o == '0 && !force_en_o)
    else $error("not clear after reset");
  AST_FORCE_ON: assert property (force_set_i |=> force_en_o)
    else $error("force flag not set");
  AST_FORCE_OFF: assert property (force_clear_i && !force_set_i |=> !force_en_o)
    else $error("force flag not cleared");
  AST_FORCE_HOLD: assert property (!force_set_i && !force_clear_i |=> $stable(force_en_o))
    else $error("force flag moved");
  AST_WRITE: assert property (force_en_o && force_write_i && !force_clear_i
    |=> outputs_o == $past(force_value_i))
    else $error("forced value not driven");
  AST_NO_WRITE: assert property (force_en_o && !force_write_i && !force_clear_i
    |=> $stable(outputs_o))
    else $error("forced outputs moved");
  AST_MATRIX: assert property (!force_en_o |-> outputs_o == matrix_status_o)
    else $error("outputs not matrix result");
  AST_RELEASE: assert property (rel_s |=> matrix_status_o == '0)
    else $error("latch not released");
endmodule : orm_top_monitor
bind orm_top orm_top_monitor #(.N_IN(N_IN), .N_LOGIC(N_LOGIC)) u_orm_top_monitor (.*);

// ==== dv/orm_src_model.sv ====
/* source side model: stage and logic outputs, registered on the clock. */
`timescale 1ns/100ps
module orm_src_model (
  input  wire logic        sys_clk_i,
  input  wire logic [23:0] want_i,
  output logic      [15:0] signals_o,
  output logic      [7:0]  logic_outs_o
);
  initial {logic_outs_o, signals_o} = '0;
  // logic outputs ride on rows 16 up
  always @(posedge sys_clk_i) {logic_outs_o, signals_o} <= want_i;
endmodule : orm_src_model

// ==== dv/tb.sv ====
/* self-checking bench for orm_top; source model on the input side. */
`timescale 1ns/100ps
module tb;
  import orm_pkg::*;
  logic sys_clk_i = 0, reset_i = 1, xp_select_i = 0, enter_key_i = 0;
  logic tool_release_i = 0, force_set_i = 0, force_clear_i = 0, force_write_i = 0;
  logic [15:0] signals_i;
  logic [7:0]  logic_outs_i, xp_row_i = 0;
  logic [3:0]  xp_col_i = 0;
  logic [8:0]  out_latching_i = 0;
  logic [23:0] want = 0;
  orm_outs_t   force_value_i = '0, outputs_o, matrix_status_o;
  logic        force_en_o;
  int          err_count = 0, checks_done = 0, cyc = 0;
  orm_top u_orm_top (.*);
  orm_src_model u_orm_src_model (.sys_clk_i, .want_i(want), .signals_o(signals_i),
    .logic_outs_o(logic_outs_i));
  initial begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic step(int n);
    repeat (n) @(posedge sys_clk_i);
    #2;
  endtask : step
  task automatic chk(string what, logic [8:0] seen, logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic pulse(ref logic s);
    s = 1;
    step(1);
    s = 0;
    step(1);
  endtask : pulse
  task automatic sel(logic [7:0] r, logic [3:0] c);
    xp_row_i = r;
    xp_col_i = c;
    pulse(xp_select_i);
  endtask : sel
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  always @(posedge sys_clk_i) if (++cyc == 3000) begin
    err_count++;
    end_of_test();
  end
  initial begin
    step(16);
    reset_i = 0;
    chk("reset", outputs_o, '0);
    sel(0, 0);
    sel(1, 0);
    sel(16, 8);
    want = 24'h010002;
    step(3);
    chk("or", outputs_o, 9'h005);
    want = 0;
    step(3);
    chk("drop", outputs_o, 9'h000);
    sel(2, 7);
    sel(2, 7);
    want = 24'h4;
    step(3);
    want = 0;
    step(3);
    chk("xp hold", outputs_o, 9'h002);
    pulse(enter_key_i);
    step(2);
    chk("enter", outputs_o, 9'h000);
    sel(2, 7);
    want = 24'h4;
    step(3);
    chk("xp off", outputs_o, 9'h000);
    out_latching_i = 9'h002;
    sel(3, 1);
    want = 24'h8;
    step(3);
    want = 0;
    step(3);
    chk("out hold", outputs_o, 9'h008);
    pulse(tool_release_i);
    step(2);
    chk("tool", outputs_o, 9'h000);
    force_value_i = 9'h1a5;
    pulse(force_write_i);
    step(2);
    chk("refused", outputs_o, 9'h000);
    want = 24'h1;
    pulse(force_set_i);
    pulse(force_write_i);
    step(1);
    chk("forced", outputs_o, 9'h1a5);
    chk("matrix", matrix_status_o, 9'h004);
    pulse(force_clear_i);
    step(1);
    chk("unforced", outputs_o, 9'h004);
    end_of_test();
  end
endmodule : tb
